//--- core/adcc_map.vh
// Register map, field positions and constants of the correction controls
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// Register indices; byte address is four times the index
`define ADCC_IDX_CORE_RESET 10'h000
`define ADCC_IDX_OFFSET_CTRL 10'h068
`define ADCC_IDX_ZONE_SELECT 10'h0A2
`define ADCC_IDX_STATUS 10'h0A3
`define ADCC_IDX_GAIN_A 10'h0A6
`define ADCC_IDX_GAIN_B 10'h1A6

// Writable bit masks; all other bits read as zero
`define ADCC_MASK_CORE_RESET 8'h01
`define ADCC_MASK_OFFSET_CTRL 8'hA7
`define ADCC_MASK_ZONE_SELECT 8'h0F
`define ADCC_MASK_GAIN 8'h0F

// Reset values
`define ADCC_RST_REG 8'h00

// Field positions
`define ADCC_BIT_CORE_RESET 0
`define ADCC_BIT_HOLD_HI 7
`define ADCC_BIT_HOLD_MID 5
`define ADCC_BIT_HOLD_LO 1
`define ADCC_BIT_BYPASS 2
`define ADCC_BIT_ZONE_EN 3

// Offset hold codes
`define ADCC_HOLD_RUN 3'h3
`define ADCC_HOLD_FREEZE 3'h7

// Zone codes
`define ADCC_ZONE_FIRST 3'h0
`define ADCC_ZONE_SECOND 3'h1
`define ADCC_ZONE_THIRD 3'h2
`define ADCC_ZONE_FOURTH 3'h3

// Gain: highest legal code, fraction bits of the coefficient
`define ADCC_GAIN_MAX 4'hB
`define ADCC_GAIN_FRAC 12

// Offset estimator: leak shift and number of interleave phases
`define ADCC_EST_SHIFT 6
`define ADCC_EST_PHASES 8

`endif

//--- core/adcc_ctrl.v
// Correction control registers with offset corrector and digital gain stage
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.vh"

// Behaviour
// - Offset hold code is bits 7, 5 and 1 read together as one code.
// - Hold code 111 freezes estimation, last correction keeps being applied.
// - Four-bit gain code scales samples ahead of the down-converters, to 11 dB.
// - Gain register exists separately for channel A and channel B.
// - Core reset bit 0 resets whole digital core; host pulses 0, 1, 0.
// - Zone settings take effect only when the core reset bit is pulsed.
// - Zone register bit 3 enables explicit zone specification.
// - Zone 000 first band, 001 second band, 010 third band.
// - Zone 011 selects the fourth band.
module adcc_ctrl (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Converter samples, same clock
    input wire sample_valid,
    input wire [13:0] sample_a,
    input wire [13:0] sample_b,
    // Samples to the down-converters
    output reg down_converter_valid,
    output reg [13:0] down_converter_a,
    output reg [13:0] down_converter_b,
    // Analog correction loop and core status
    output reg zone_select_enable,
    output reg [2:0] zone_active,
    output reg [3:0] zone_band_onehot,
    output wire core_logic_reset_pulse
);

    // Register storage
    reg [7:0] core_reset_control;
    reg [7:0] offset_corrector_control;
    reg [7:0] band_zone_select;
    reg [7:0] pre_downconvert_gain_a;
    reg [7:0] pre_downconvert_gain_b;
    reg reset_bit_q;

    // Offset estimator state
    reg [19:0] est_acc [0:`ADCC_EST_PHASES-1];
    reg [2:0] phase;

    // Pipeline stage one
    reg s1_valid;
    reg [13:0] s1_a;
    reg [13:0] s1_b;

    wire [9:0] reg_idx;
    wire wr_en;
    wire core_rst;
    wire [2:0] hold_code;
    wire freeze;
    wire bypass;
    reg [7:0] read_mux;

    // Saturate a wide signed value into the 14-bit sample range
    function [13:0] sat14;
        input [19:0] v;
        begin
            if (!v[19] && (v[18:13] != 6'h00)) begin
                sat14 = 14'h1FFF;
            end else if (v[19] && (v[18:13] != 6'h3F)) begin
                sat14 = 14'h2000;
            end else begin
                sat14 = v[13:0];
            end
        end
    endfunction

    // Gain code to linear coefficient, fraction bits per map
    function [14:0] gain_coef;
        input [3:0] code;
        begin
            case (code)
                4'h0: gain_coef = 15'h1000;
                4'h1: gain_coef = 15'h11F4;
                4'h2: gain_coef = 15'h1425;
                4'h3: gain_coef = 15'h169A;
                4'h4: gain_coef = 15'h195C;
                4'h5: gain_coef = 15'h1C74;
                4'h6: gain_coef = 15'h1FED;
                4'h7: gain_coef = 15'h23D2;
                4'h8: gain_coef = 15'h2831;
                4'h9: gain_coef = 15'h2D18;
                4'hA: gain_coef = 15'h3299;
                4'hB: gain_coef = 15'h38C5;
                // Unused codes fall back to unity rather than garbage
                default: gain_coef = 15'h1000;
            endcase
        end
    endfunction

    // Zone code to one-hot band for the correction loop
    function [3:0] zone_band;
        input [2:0] code;
        begin
            case (code)
                `ADCC_ZONE_FIRST: zone_band = 4'h1;
                `ADCC_ZONE_SECOND: zone_band = 4'h2;
                `ADCC_ZONE_THIRD: zone_band = 4'h4;
                `ADCC_ZONE_FOURTH: zone_band = 4'h8;
                default: zone_band = 4'h0;
            endcase
        end
    endfunction

    // Bus decode; a write lands at the edge where ack is seen high
    assign reg_idx = wb_adr_i[11:2];
    assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];

    // Core reset held for as long as the bit stays set
    assign core_rst = rst | core_reset_control[`ADCC_BIT_CORE_RESET];
    assign core_logic_reset_pulse = core_reset_control[`ADCC_BIT_CORE_RESET];

    // Hold code from three scattered bits
    assign hold_code = {offset_corrector_control[`ADCC_BIT_HOLD_HI],
                        offset_corrector_control[`ADCC_BIT_HOLD_MID],
                        offset_corrector_control[`ADCC_BIT_HOLD_LO]};
    assign freeze = (hold_code == `ADCC_HOLD_FREEZE);
    assign bypass = offset_corrector_control[`ADCC_BIT_BYPASS];

    // Register writes; reserved bits are masked so they read as zero
    always @(posedge clk) begin
        if (rst) begin
            core_reset_control <= `ADCC_RST_REG;
            offset_corrector_control <= `ADCC_RST_REG;
            band_zone_select <= `ADCC_RST_REG;
            pre_downconvert_gain_a <= `ADCC_RST_REG;
            pre_downconvert_gain_b <= `ADCC_RST_REG;
        end else if (wr_en) begin
            case (reg_idx)
                `ADCC_IDX_CORE_RESET:
                    core_reset_control <=
                        wb_dat_i[7:0] & `ADCC_MASK_CORE_RESET;
                `ADCC_IDX_OFFSET_CTRL:
                    offset_corrector_control <=
                        wb_dat_i[7:0] & `ADCC_MASK_OFFSET_CTRL;
                `ADCC_IDX_ZONE_SELECT:
                    band_zone_select <=
                        wb_dat_i[7:0] & `ADCC_MASK_ZONE_SELECT;
                `ADCC_IDX_GAIN_A:
                    pre_downconvert_gain_a <=
                        wb_dat_i[7:0] & `ADCC_MASK_GAIN;
                `ADCC_IDX_GAIN_B:
                    pre_downconvert_gain_b <=
                        wb_dat_i[7:0] & `ADCC_MASK_GAIN;
                default: ;
            endcase
        end
    end

    // Read multiplexer; unmapped indices answer zero
    always @* begin
        case (reg_idx)
            `ADCC_IDX_CORE_RESET: read_mux = core_reset_control;
            `ADCC_IDX_OFFSET_CTRL: read_mux = offset_corrector_control;
            `ADCC_IDX_ZONE_SELECT: read_mux = band_zone_select;
            `ADCC_IDX_STATUS:
                read_mux = {3'h0, freeze, zone_select_enable, zone_active};
            `ADCC_IDX_GAIN_A: read_mux = pre_downconvert_gain_a;
            `ADCC_IDX_GAIN_B: read_mux = pre_downconvert_gain_b;
            default: read_mux = 8'h00;
        endcase
    end

    // Ack one cycle after the request, dropped the cycle after
    always @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
                wb_dat_o <= {24'h000000, read_mux};
            end
        end
    end

    // Zone settings latch on the falling edge of the reset bit only,
    // so writes to the zone field alone never disturb the loop
    always @(posedge clk) begin
        if (rst) begin
            reset_bit_q <= 1'b0;
            zone_select_enable <= 1'b0;
            zone_active <= `ADCC_ZONE_FIRST;
            zone_band_onehot <= 4'h0;
        end else begin
            reset_bit_q <= core_reset_control[`ADCC_BIT_CORE_RESET];
            if (reset_bit_q &&
                !core_reset_control[`ADCC_BIT_CORE_RESET]) begin
                zone_select_enable <=
                    band_zone_select[`ADCC_BIT_ZONE_EN];
                zone_active <= band_zone_select[2:0];
                if (band_zone_select[`ADCC_BIT_ZONE_EN]) begin
                    zone_band_onehot <=
                        zone_band(band_zone_select[2:0]);
                end else begin
                    zone_band_onehot <= 4'h0;
                end
            end
        end
    end

    // Interleave phase counter; spurs at fs/8 multiples come from
    // eight sub-converter offsets, one estimator per phase
    always @(posedge clk) begin
        if (core_rst) begin
            phase <= 3'h0;
        end else if (sample_valid) begin
            phase <= phase + 3'h1;
        end
    end

    // Leaky per-phase offset estimate; frozen estimates keep applying
    genvar gi;
    generate
        for (gi = 0; gi < `ADCC_EST_PHASES; gi = gi + 1) begin : g_est
            wire [19:0] est_now;
            assign est_now = {{`ADCC_EST_SHIFT{est_acc[gi][19]}},
                              est_acc[gi][19:`ADCC_EST_SHIFT]};
            always @(posedge clk) begin
                if (core_rst) begin
                    est_acc[gi] <= 20'h00000;
                end else if (sample_valid && (phase == gi) &&
                             !freeze && !bypass) begin
                    est_acc[gi] <= est_acc[gi]
                        + {{6{sample_b[13]}}, sample_b} - est_now;
                end
            end
        end
    endgenerate

    // Offset correction on channel B, stage one
    wire [19:0] est_sel;
    wire [19:0] corr_b;
    assign est_sel = {{`ADCC_EST_SHIFT{est_acc[phase][19]}},
                      est_acc[phase][19:`ADCC_EST_SHIFT]};
    assign corr_b = {{6{sample_b[13]}}, sample_b} - est_sel;

    always @(posedge clk) begin
        if (core_rst) begin
            s1_valid <= 1'b0;
            s1_a <= 14'h0000;
            s1_b <= 14'h0000;
        end else begin
            s1_valid <= sample_valid;
            if (sample_valid) begin
                s1_a <= sample_a;
                if (bypass) begin
                    s1_b <= sample_b;
                end else begin
                    s1_b <= sat14(corr_b);
                end
            end
        end
    end

    // Gain products; full width kept so saturation sees true overflow
    wire signed [29:0] prod_a;
    wire signed [29:0] prod_b;
    assign prod_a = $signed(s1_a)
        * $signed({1'b0, gain_coef(pre_downconvert_gain_a[3:0])});
    assign prod_b = $signed(s1_b)
        * $signed({1'b0, gain_coef(pre_downconvert_gain_b[3:0])});

    // Stage two, scaled and saturated samples to the down-converters
    always @(posedge clk) begin
        if (core_rst) begin
            down_converter_valid <= 1'b0;
            down_converter_a <= 14'h0000;
            down_converter_b <= 14'h0000;
        end else begin
            down_converter_valid <= s1_valid;
            if (s1_valid) begin
                down_converter_a <= sat14({{2{prod_a[29]}},
                    prod_a[29:`ADCC_GAIN_FRAC]});
                down_converter_b <= sat14({{2{prod_b[29]}},
                    prod_b[29:`ADCC_GAIN_FRAC]});
            end
        end
    end

endmodule
`default_nettype wire

//--- verification/adcc_monitor.sv
// Assertion checker watching the correction control ports
`timescale 1ns/1ps
`default_nettype none
module adcc_monitor (
    // Clock, reset and bus
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Samples and zone
    input wire logic sample_valid,
    input wire logic down_converter_valid,
    input wire logic [13:0] down_converter_a,
    input wire logic zone_select_enable,
    input wire logic [2:0] zone_active,
    input wire logic [3:0] zone_band_onehot,
    input wire logic core_logic_reset_pulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Bus answers one cycle after the request, for one cycle
    a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    // Zone outputs move only right after the core reset bit falls
    a_zone_steady: assert property (!$fell(core_logic_reset_pulse) |=>
        $stable(zone_active) && $stable(zone_select_enable))
        else $error("zone changed without core reset pulse");
    a_zone_onehot: assert property (zone_band_onehot ==
        ((zone_select_enable && !zone_active[2]) ? 4'h1 << zone_active : 4'h0))
        else $error("band one-hot does not match zone code");
    // Samples come out two edges after they are taken
    a_smp_latency: assert property ((sample_valid && !core_logic_reset_pulse)
        ##1 !core_logic_reset_pulse |=> down_converter_valid)
        else $error("sample lost in gain stage");
    a_smp_cause: assert property (down_converter_valid |-> $past(sample_valid, 2))
        else $error("output sample without input sample");
    a_core_drop: assert property (core_logic_reset_pulse |=> !down_converter_valid)
        else $error("sample passed during core reset");
    // Cover the main scenarios
    c_pulse: cover property ($fell(core_logic_reset_pulse));
    c_sat: cover property (down_converter_valid && down_converter_a == 14'h1FFF);
    c_zone: cover property (wb_ack_o && zone_select_enable);
endmodule
bind adcc_ctrl adcc_monitor u_mon (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_valid(sample_valid), .down_converter_valid(down_converter_valid),
    .down_converter_a(down_converter_a),
    .zone_select_enable(zone_select_enable), .zone_active(zone_active),
    .zone_band_onehot(zone_band_onehot),
    .core_logic_reset_pulse(core_logic_reset_pulse));
`default_nettype wire

//--- verification/tb_adc_digital_correction_ctrl.sv
// Self-checking bench for the correction control registers
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.vh"
module tb_adc_digital_correction_ctrl;
    // Byte addresses of the registers
    localparam logic [11:0] A_CR = 12'h000, A_OFS = 12'h1A0, A_ZN = 12'h288;
    localparam logic [11:0] A_GA = 12'h298, A_GB = 12'h698;
    logic clk, rst, cyc, stb, we, ack, sv, dv, zen, crp;
    logic [11:0] adr;
    logic [3:0] sel, zoh;
    logic [31:0] wd, rd, q;
    logic [13:0] sa, sb, da, db;
    logic [2:0] zact;
    int fails, n_compared, cyc_cnt;
    adcc_ctrl uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(rd), .wb_ack_o(ack), .sample_valid(sv), .sample_a(sa),
        .sample_b(sb), .down_converter_valid(dv), .down_converter_a(da),
        .down_converter_b(db), .zone_select_enable(zen), .zone_active(zact),
        .zone_band_onehot(zoh), .core_logic_reset_pulse(crp));
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Hang guard, well above the few thousand cycles used
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            fails++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, hi, input logic [13:0] g);
        n_compared++;
        if ($isunknown(g) || $signed(g) < lo || $signed(g) > hi) begin
            fails++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, $signed(g));
        end
    endtask
    // One classic cycle; waits for ack, bounded
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 50);
        q = rd;
        {cyc, stb} <= 2'b00;
        // A missing ack ends the run through the one verdict
        if (ack !== 1'b1) begin
            fails++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic feed(input logic [13:0] a, b, input int n);
        sv <= 1'b1;
        {sa, sb} <= {a, b};
        repeat (n) @(posedge clk);
        sv <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic pulse_core;
        wr(A_CR, 32'h01);
        wr(A_CR, 32'h00);
        repeat (2) @(posedge clk);
    endtask
    // Reset values, offset write-back, per-channel gain, unmapped place
    task automatic t_regs;
        rdchk("core", A_CR, 32'h0);
        rdchk("offset", A_OFS, 32'h0);
        rdchk("zone", A_ZN, 32'h0);
        rdchk("gain_b", A_GB, 32'h0);
        wr(A_OFS, 32'hA6);
        rdchk("offset", A_OFS, 32'hA6);
        wr(A_GA, 32'h05);
        wr(A_GB, 32'h0B);
        rdchk("gain_a", A_GA, 32'h05);
        rdchk("gain_b", A_GB, 32'h0B);
        wr(12'h400, 32'hFF);
        rdchk("unmapped", 12'h400, 32'h0);
    endtask
    // Every zone code, latched only by the core reset pulse
    task automatic t_zone;
        for (int c = 0; c < 4; c++) begin
            wr(A_ZN, 32'h08);
            wr(A_ZN, 32'h08 | c);
            repeat (2) @(posedge clk);
            chk("zone held", (c == 0) ? 0 : 4'h8 | (c - 1), {zen, zact});
            pulse_core();
            chk("zone", {1'b1, c[2:0], 4'h1 << c}, {zen, zact, zoh});
        end
        wr(A_ZN, 32'h02);
        pulse_core();
        chk("zone off", 8'h20, {zen, zact, zoh});
    endtask
    // Unity and top gain with saturation, corrector bypassed
    task automatic t_gain;
        wr(A_GA, 32'h00);
        wr(A_GB, 32'h00);
        wr(A_OFS, 32'h26);
        feed(14'h04D2, 14'h3B2E, 1);
        chk("gain0 a", 14'h04D2, da);
        chk("bypass b", 14'h3B2E, db);
        wr(A_GA, 32'h0B);
        wr(A_GB, 32'h0B);
        feed(14'h1000, 14'h3000, 1);
        chk("sat a", 14'h1FFF, da);
        chk("sat b", 14'h2000, db);
        feed(14'h0100, 14'h0000, 1);
        chk("gain11 a", 14'h038C, da);
    endtask
    // Offset removal, freeze, and clearing by the core reset
    task automatic t_offset;
        wr(A_GB, 32'h00);
        wr(A_OFS, 32'h22);
        feed(14'h0000, 14'h03E8, 2000);
        chk_rng("corrected b", -100, 100, db);
        wr(A_OFS, 32'hA2);
        rdchk("status", 12'h28C, 32'h12);
        feed(14'h0000, 14'h0000, 200);
        chk_rng("frozen b", -1000, -900, db);
        pulse_core();
        feed(14'h0000, 14'h03E8, 1);
        chk_rng("cleared b", 950, 1000, db);
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        sel = 4'hF;
        {cyc, stb, we, sv, adr, wd, sa, sb} = '0;
        {fails, n_compared, cyc_cnt} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_zone();
        t_gain();
        t_offset();
        stop_test();
    end
endmodule
`default_nettype wire
